// ==== pkg/pdsm_pkg.sv ====
// Package: register map, field layout and shared types for the divider and spread modulator block
package pdsm_pkg;

  // ****************************************************************
  // Register offsets (byte addresses, one 32-bit word each)
  // ****************************************************************
  localparam logic [7:0] PDSM_OFF_FB2 = 8'h00;     // Third PLL feedback integer and prescaler
  localparam logic [7:0] PDSM_OFF_BANK0 = 8'h04;   // Bank post-divider registers, four per bank step
  localparam logic [7:0] PDSM_OFF_SS0 = 8'h20;     // Modulator control, first PLL
  localparam logic [7:0] PDSM_OFF_SD0 = 8'h24;     // Samples 0..7, first PLL
  localparam logic [7:0] PDSM_OFF_SD0H = 8'h28;    // Samples 8..11, first PLL
  localparam logic [7:0] PDSM_OFF_SS1 = 8'h30;     // Modulator control, second PLL
  localparam logic [7:0] PDSM_OFF_SD1 = 8'h34;     // Samples 0..7, second PLL
  localparam logic [7:0] PDSM_OFF_SD1H = 8'h38;    // Samples 8..11, second PLL
  localparam logic [7:0] PDSM_OFF_STAT = 8'h3c;    // Status, read only

  // ****************************************************************
  // Field positions and sizes
  // ****************************************************************
  localparam int PDSM_NBANK = 5;                   // Banks with a post-divider
  localparam int PDSM_NSAMP = 12;                  // Stored samples per PLL
  localparam int PDSM_CTL_STEP_LSB = 0;            // Step period code [3:0]
  localparam int PDSM_CTL_CNT_LSB = 4;             // Quadrant sample pair count [7:4]
  localparam int PDSM_CTL_OFF_LSB = 8;             // Offset [13:8]
  localparam int PDSM_CTL_LSB_RANDOMIZE_ENABLE_BIT = 16;           // LSB randomize enable
  localparam int PDSM_CTL_X2_BIT = 17;             // Amplitude double
  localparam int PDSM_BANK_SEL_LSB = 16;           // Post select [17:16]
  localparam int PDSM_FB_PRE_LSB = 16;             // Prescaler [23:16]

  // ****************************************************************
  // Encodings and reset values
  // ****************************************************************
  localparam logic [1:0] PDSM_PSEL_OFF = 2'h0;
  localparam logic [1:0] PDSM_PSEL_DIV1 = 2'h1;
  localparam logic [1:0] PDSM_PSEL_DIV2 = 2'h2;
  localparam logic [1:0] PDSM_PSEL_CNT = 2'h3;
  localparam logic [9:0] PDSM_CNT_ADD = 10'h002;   // Programmed count plus two
  localparam logic [4:0] PDSM_STEP_ADD = 5'h02;    // Step code plus two
  localparam logic [31:0] PDSM_RST_WORD = 32'h0000_0000;
  localparam logic [15:0] PDSM_LFSR_SEED = 16'hace1;

  // Configuration carried into one modulator
  typedef struct packed {
    logic [3:0] step;
    logic [3:0] cnt;
    logic [5:0] offset;
    logic lsb_randomize_enable;
    logic x2;
    logic [47:0] samp;
  } pdsm_ss_cfg_s;

  // Wishbone request
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [7:0] adr;
    logic [31:0] dat;
  } pdsm_wb_req_s;

endpackage

// ==== sim/pdsm_host_model.sv ====
// Wishbone host model that plays the software side of the register bus
`timescale 1ns/10ps
module pdsm_host_model
  import pdsm_pkg::*;
(
  input wire logic clk_i,
  input wire logic ack_i,
  input wire logic [31:0] dat_i,
  output pdsm_wb_req_s req_o
);
  // Bus idle from time zero
  initial begin
    req_o = '0;
  end

  // One classic cycle, held until ack is sampled; ok_o low if ack never came
  task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat, input logic [3:0] sel,
                      output logic [31:0] rd, output logic ok_o);
    int n = 0;
    @(posedge clk_i);
    req_o <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: sel, adr: adr, dat: dat};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_i !== 1'b1 && n < 16);
    ok_o = (ack_i === 1'b1);
    rd = dat_i;
    req_o <= '0;
  endtask
endmodule // pdsm_host_model

// ==== sim/pdsm_top_tb.sv ====
// Self-checking bench for the divider and spread modulator block
`timescale 1ns/10ps
module pdsm_top_tb
  import pdsm_pkg::*;
;
  logic clk_i;
  logic rst_i;
  pdsm_wb_req_s req; // Host request
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [PDSM_NBANK-1:0] bank_clk_o;
  logic vco_min_o;
  logic pll2_pwr_o;
  logic [7:0] frac_o [2]; // Both modulators
  int n_mismatch;
  int samples_checked;
  int seed = 32'h8606ba5b;
  logic [31:0] rd;
  logic ok;
  logic [7:0] ra [9] = '{8'h00, 8'h04, 8'h14, 8'h20, 8'h28, 8'h38, 8'h3c, 8'h2c, 8'h40};

  pdsm_top u_pdsm_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(req.cyc), .wb_stb_i(req.stb),
    .wb_we_i(req.we), .wb_sel_i(req.sel), .wb_adr_i(req.adr), .wb_dat_i(req.dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .bank_clk_o(bank_clk_o), .vco_min_o(vco_min_o), .pll2_pwr_o(pll2_pwr_o),
    .frac0_o(frac_o[0]), .frac1_o(frac_o[1]));

  pdsm_host_model u_pdsm_host_model (.clk_i(clk_i), .ack_i(wb_ack_o), .dat_i(wb_dat_o), .req_o(req));

  // ****************************************************************
  // Compare, bus and measuring helpers
  // ****************************************************************
  task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_cnt(input string what, input int exp, input int got);
    samples_checked++;
    if (got != exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
    u_pdsm_host_model.xfer(1'b1, a, d, s, rd, ok);
    chk_val("write ack", 32'h1, {31'h0, ok});
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    u_pdsm_host_model.xfer(1'b0, a, 32'h0, 4'hf, rd, ok);
    chk_val("read ack", 32'h1, {31'h0, ok});
    chk_val($sformatf("read %h", a), exp, rd);
  endtask

  // Bank clock period in cycles for a post select and count
  function automatic int exp_per(input logic [1:0] s, input int q);
    case (s)
      2'h1: return 2;
      2'h2: return 4;
      2'h3: return 2 * (q + 2);
      default: return 0;
    endcase
  endfunction

  // Gap between last two entries of bank src high, or of modulator src-5 into pk; also the peak seen
  task automatic gap(input int src, input logic [7:0] pk, input int lim, output int per, output logic [7:0] mx);
    int t0 = 0;
    int n = 0;
    logic p = 1'b1;
    logic h;
    per = 0;
    mx = 8'h80;
    for (int t = 0; t < lim && n < 3; t++) begin
      @(posedge clk_i);
      h = (src < 5) ? bank_clk_o[src] : (frac_o[src-5] === pk);
      if (src >= 5 && $signed(frac_o[src-5]) > $signed(mx)) mx = frac_o[src-5];
      if (h === 1'b1 && p === 1'b0) begin
        if (n > 0) per = t - t0;
        t0 = t;
        n++;
      end
      p = h;
    end
  endtask

  // Cycles off v (and off v with lsb flipped), and cycles at v with lsb flipped
  task automatic watch(input int k, input logic [7:0] v, input int n, output int bad, output int fl);
    bad = 0;
    fl = 0;
    repeat (n) begin
      @(posedge clk_i);
      if (frac_o[k] !== v && frac_o[k] !== (v ^ 8'h01)) bad++;
      if (frac_o[k] === (v ^ 8'h01)) fl++;
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Free-running 50 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // Hang guard
  initial begin
    repeat (80000) @(posedge clk_i);
    n_mismatch++;
    $display("watchdog expired");
    summarize();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    int q, e, per, stp, cnt, off, sum, bad, fl;
    logic [7:0] mx, pk, cb;
    logic [47:0] smp;
    rst_i = 1'b1;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    // Unmapped and read-only writes are dropped; all reads start at zero
    wr(8'h40, 32'hffff_ffff);
    wr(PDSM_OFF_STAT, 32'hffff_ffff);
    foreach (ra[i]) rdc(ra[i], PDSM_RST_WORD);
    $display("test registers done");
    wr(PDSM_OFF_FB2, 32'h0001_0000);
    repeat (3) @(posedge clk_i);
    chk_val("vco_min_o", 32'h1, {31'h0, vco_min_o});
    // Feedback integer of five keeps clear of four, eight and sixteen
    wr(PDSM_OFF_FB2, 32'h0001_0005);
    repeat (3) @(posedge clk_i);
    chk_val("vco_min_o", 32'h0, {31'h0, vco_min_o});
    // Every bank through every post select mode
    for (int b = 0; b < PDSM_NBANK; b++) begin
      for (int m = 0; m < 4; m++) begin
        q = (b == 0 && m == 3) ? 1021 : $unsigned($random(seed)) % 8;
        wr(PDSM_OFF_BANK0 + 8'(4 * b), {14'h0, 2'(m), 6'h0, 10'(q)});
        e = exp_per(2'(m), q);
        gap(b, 8'h00, (e == 0) ? 100 : 3 * e + 20, per, mx);
        chk_cnt($sformatf("bank%0d period", b), e, per);
      end
    end
    wr(PDSM_OFF_BANK0, 32'h0001_0005);
    wr(PDSM_OFF_BANK0, 32'h0000_00ff, 4'h1);
    rdc(PDSM_OFF_BANK0, 32'h0001_00ff);
    wr(PDSM_OFF_FB2, 32'h0000_0005);
    gap(0, 8'h00, 100, per, mx);
    chk_cnt("bank0 powered down", 0, per);
    chk_val("pll2_pwr_o", 32'h0, {31'h0, pll2_pwr_o});
    $display("test dividers done");
    // Random profiles on both modulators, with and without doubling
    for (int k = 0; k < 2; k++) begin
      for (int x = 0; x < 2; x++) begin
        cb = k ? PDSM_OFF_SS1 : PDSM_OFF_SS0;
        stp = 5 + $unsigned($random(seed)) % 10;
        cnt = 1 + $unsigned($random(seed)) % 6;
        off = 1 + $unsigned($random(seed)) % 20;
        smp = 48'({$random(seed), $random(seed)});
        sum = 0;
        for (int i = 0; i < 2 * cnt; i++) begin
          smp[4*i+:4] = 4'(1 + $unsigned($random(seed)) % 3);
          sum += smp[4*i+:4];
        end
        wr(cb, 32'h0);
        wr(cb + 8'h04, smp[31:0]);
        wr(cb + 8'h08, {16'h0, smp[47:32]});
        // Feedback adjust is set by software outside this block when spread runs
        // Doubling chosen both ways, as software would for mid-range amplitude
        wr(cb, {14'h0, 1'(x), 1'b0, 2'h0, 6'(off), 4'(cnt), 4'(stp)});
        e = 8 * cnt * (stp + 2);
        pk = 8'(off + sum * (x + 1));
        gap(5 + k, pk, 3 * e + 50, per, mx);
        chk_cnt("modulation period", e, per);
        chk_val("waveform peak", {24'h0, pk}, {24'h0, mx});
        wr(cb, 32'h0);
        repeat (e + 10) @(posedge clk_i);
        watch(k, 8'h00, 50, bad, fl);
        chk_cnt("modulator off", 0, bad + fl);
      end
    end
    $display("test modulators done");
    // Flat profile: pure fractional offset, then with dithering
    wr(PDSM_OFF_SD0, 32'h0);
    wr(PDSM_OFF_SD0H, 32'h0);
    off = 2 * (1 + $unsigned($random(seed)) % 20);
    wr(PDSM_OFF_SS0, {16'h0, 2'h0, 6'(off), 4'h1, 4'h5});
    repeat (120) @(posedge clk_i);
    watch(0, 8'(off), 200, bad, fl);
    chk_cnt("offset hold", 0, bad + fl);
    wr(PDSM_OFF_SS0, {14'h0, 2'h1, 2'h0, 6'(off), 4'h1, 4'h5});
    repeat (120) @(posedge clk_i);
    watch(0, 8'(off), 200, bad, fl);
    chk_cnt("dither range", 0, bad);
    chk_val("dither active", 32'h1, {31'h0, fl > 0});
    $display("test dither done");
    summarize();
  end
endmodule // pdsm_top_tb

// ==== verilog/pdsm_post_div.sv ====
// Module: one bank post-divider with select and final divide-by-two
`timescale 1ns/10ps
module pdsm_post_div
  import pdsm_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [1:0] sel_i,          // Post select
  input wire logic [9:0] count_i,        // Programmed count
  input wire logic run_i,                // Source PLL powered
  output logic clk_o                     // Bank clock output
);

  logic [10:0] cnt_q;                    // Divide counter
  logic tick_q;                          // Divided edge enable
  logic out_q;                           // Final toggle stage
  wire logic [10:0] limit;               // Terminal count
  wire logic en;                         // Bank runs

  // Terminal count per selection
  assign limit = (sel_i == PDSM_PSEL_DIV2) ? 11'h001 :
                 (sel_i == PDSM_PSEL_CNT) ? {1'b0, count_i} + {1'b0, PDSM_CNT_ADD} - 11'h001 : 11'h000;
  assign en = run_i && (sel_i != PDSM_PSEL_OFF);

  // Counter gives one enable every limit+1 cycles
  always_ff @(posedge clk_i) begin
    if (rst_i || !en) begin
      cnt_q <= 11'h000;
      tick_q <= 1'b0;
    end else if (cnt_q >= limit) begin
      cnt_q <= 11'h000;
      tick_q <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 11'h001;
      tick_q <= 1'b0;
    end
  end

  // Extra divide-by-two before the pin; held low when off
  always_ff @(posedge clk_i) begin
    if (rst_i || !en) begin
      out_q <= 1'b0;
    end else if (tick_q) begin
      out_q <= ~out_q;
    end
  end

  assign clk_o = out_q;

  a_off_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
    (sel_i == PDSM_PSEL_OFF) [*2] |-> !clk_o) else $error("disabled bank toggles");

endmodule // pdsm_post_div

// ==== verilog/pdsm_ss_mod.sv ====
// Module: spread spectrum and fractional offset modulator for one PLL
`timescale 1ns/10ps
module pdsm_ss_mod
  import pdsm_pkg::*;
(
  input wire logic clk_i,                // Phase-detector rate clock
  input wire logic rst_i,
  input wire pdsm_ss_cfg_s cfg_i,        // Live configuration
  output logic [7:0] frac_o,             // Fractional adder in 1/64 units, signed about offset
  output logic active_o,                 // Modulator running
  output logic period_o                  // Pulse at period start
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef enum logic [3:0] {
    PDSM_Q_UP = 4'b0001, PDSM_Q_DN = 4'b0010, PDSM_Q_NUP = 4'b0100, PDSM_Q_NDN = 4'b1000
  } pdsm_quad_e;
  pdsm_quad_e quad_q;                    // Current quadrant
  pdsm_ss_cfg_s shd_q;                   // Shadow copy used during a period
  logic [4:0] hold_q;                    // Cycles in current sample
  logic [3:0] idx_q;                     // Sample index within quadrant
  logic [7:0] acc_q;                     // Running sum of deltas
  logic [15:0] lfsr_q;                   // Dither source
  logic [7:0] frac_q;
  logic per_q;

  wire logic [4:0] hold_max;
  wire logic [3:0] qlen;
  wire logic step;
  wire logic qend;
  wire logic [3:0] cur_delta;
  wire logic [7:0] amp;
  wire logic [7:0] signed_v;

  // Pick a 4-bit sample from the packed store
  function automatic logic [3:0] pick(input logic [47:0] s, input logic [3:0] i);
    pick = s[i*4 +: 4];
  endfunction

  assign hold_max = {1'b0, shd_q.step} + PDSM_STEP_ADD - 5'h01;
  assign qlen = {shd_q.cnt[2:0], 1'b0};  // Twice the low three count bits
  assign step = (hold_q >= hold_max);
  assign qend = step && (idx_q == qlen - 4'h1);
  assign cur_delta = pick(shd_q.samp, (quad_q == PDSM_Q_UP || quad_q == PDSM_Q_NUP) ? idx_q : qlen - 4'h1 - idx_q);
  assign amp = shd_q.x2 ? {acc_q[6:0], 1'b0} : acc_q;
  assign signed_v = (quad_q == PDSM_Q_NUP || quad_q == PDSM_Q_NDN) ? 8'h00 - amp : amp;

  // Hold counter, sample index and quadrant walk
  always_ff @(posedge clk_i) begin
    if (rst_i || shd_q.step == 4'h0) begin
      hold_q <= 5'h00;
      idx_q <= 4'h0;
      quad_q <= PDSM_Q_UP;
      acc_q <= 8'h00;
    end else if (step) begin
      hold_q <= 5'h00;
      idx_q <= qend ? 4'h0 : idx_q + 4'h1;
      // Accumulate on way up, unwind on way down
      acc_q <= (quad_q == PDSM_Q_UP || quad_q == PDSM_Q_NUP) ? acc_q + {4'h0, cur_delta} :
               acc_q - {4'h0, cur_delta};
      if (qend) begin
        unique case (quad_q)
          PDSM_Q_UP: quad_q <= PDSM_Q_DN;
          PDSM_Q_DN: quad_q <= PDSM_Q_NUP;
          PDSM_Q_NUP: quad_q <= PDSM_Q_NDN;
          PDSM_Q_NDN: quad_q <= PDSM_Q_UP;
          default: quad_q <= PDSM_Q_UP;
        endcase
      end
    end else begin
      hold_q <= hold_q + 5'h01;
    end
  end

  // Shadow reload only at period start or while idle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      shd_q <= '0;
    end else if (shd_q.step == 4'h0 || (qend && quad_q == PDSM_Q_NDN)) begin
      shd_q <= cfg_i;
    end
  end

  // Dither LFSR
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lfsr_q <= PDSM_LFSR_SEED;
    end else begin
      lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
    end
  end

  // Output value: offset plus waveform, lsb dithered
  always_ff @(posedge clk_i) begin
    if (rst_i || shd_q.step == 4'h0) begin
      frac_q <= 8'h00;
      per_q <= 1'b0;
    end else begin
      frac_q <= ({2'b00, shd_q.offset} + signed_v) ^ {7'h00, shd_q.lsb_randomize_enable & lfsr_q[0]};
      per_q <= qend && quad_q == PDSM_Q_NDN;
    end
  end

  assign frac_o = frac_q;
  assign active_o = (shd_q.step != 4'h0);
  assign period_o = per_q;

  a_idle_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    !active_o |=> frac_o == 8'h00) else $error("idle modulator output nonzero");
  a_hold_bound: assert property (@(posedge clk_i) disable iff (rst_i)
    hold_q <= hold_max || !active_o) else $error("hold count overran");

endmodule // pdsm_ss_mod

// ==== verilog/pdsm_top.sv ====
// Module: divider and spread modulator block with its Wishbone register file
//
// The Wishbone register port and the register offsets were decided locally.
`timescale 1ns/10ps
module pdsm_top
  import pdsm_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic [PDSM_NBANK-1:0] bank_clk_o,    // Banks with post-dividers
  output logic vco_min_o,                      // Third PLL oscillator held at minimum
  output logic pll2_pwr_o,                     // Third PLL powered
  output logic [7:0] frac0_o,                  // First PLL fractional feedback adder
  output logic [7:0] frac1_o                   // Second PLL fractional feedback adder
);

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [31:0] fb2_q;                          // Feedback integer [11:0], prescaler [23:16]
  logic [31:0] bank_q [PDSM_NBANK];            // Count [9:0], select [17:16]
  logic [31:0] ss_q [2];                       // Modulator control per PLL
  logic [31:0] sdl_q [2];                      // Samples 0..7
  logic [31:0] sdh_q [2];                      // Samples 8..11
  logic ack_q;
  logic [31:0] rdat_q;
  logic vmin_q;
  logic pwr_q;
  logic [PDSM_NBANK-1:0] bclk_q;
  logic [7:0] f0_q;
  logic [7:0] f1_q;

  // ****************************************************************
  // Decode
  // ****************************************************************
  wire logic req;
  wire logic wr;
  wire logic [31:0] wmask;
  wire logic [31:0] rd_mux;
  wire logic [PDSM_NBANK-1:0] bclk_raw;
  wire logic [7:0] fr [2];
  wire logic [1:0] act;
  wire pdsm_ss_cfg_s cfg [2];

  // Byte-lane mask from select
  function automatic logic [31:0] lanes(input logic [3:0] s);
    lanes = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction

  // Merge write data into a stored word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [31:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction

  assign req = wb_cyc_i && wb_stb_i && !ack_q;
  assign wr = req && wb_we_i;
  assign wmask = lanes(wb_sel_i);

  // Read selection; unmapped reads return zero
  assign rd_mux =
    (wb_adr_i == PDSM_OFF_FB2) ? {8'h00, fb2_q[23:16], 4'h0, fb2_q[11:0]} :
    (wb_adr_i == PDSM_OFF_BANK0) ? {14'h0, bank_q[0][17:0]} :
    (wb_adr_i == PDSM_OFF_BANK0 + 8'h04) ? {14'h0, bank_q[1][17:0]} :
    (wb_adr_i == PDSM_OFF_BANK0 + 8'h08) ? {14'h0, bank_q[2][17:0]} :
    (wb_adr_i == PDSM_OFF_BANK0 + 8'h0c) ? {14'h0, bank_q[3][17:0]} :
    (wb_adr_i == PDSM_OFF_BANK0 + 8'h10) ? {14'h0, bank_q[4][17:0]} :
    (wb_adr_i == PDSM_OFF_SS0) ? {14'h0, ss_q[0][17:0]} :
    (wb_adr_i == PDSM_OFF_SD0) ? sdl_q[0] :
    (wb_adr_i == PDSM_OFF_SD0H) ? {16'h0, sdh_q[0][15:0]} :
    (wb_adr_i == PDSM_OFF_SS1) ? {14'h0, ss_q[1][17:0]} :
    (wb_adr_i == PDSM_OFF_SD1) ? sdl_q[1] :
    (wb_adr_i == PDSM_OFF_SD1H) ? {16'h0, sdh_q[1][15:0]} :
    (wb_adr_i == PDSM_OFF_STAT) ? {14'h0, act, f1_q, f0_q} : 32'h0;

  // Bus ack one cycle after request, dropped next cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      rdat_q <= PDSM_RST_WORD;
    end else begin
      ack_q <= req;
      rdat_q <= req ? rd_mux : rdat_q;
    end
  end

  // Write of the third PLL word
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fb2_q <= PDSM_RST_WORD;
    end else if (wr && wb_adr_i == PDSM_OFF_FB2) begin
      fb2_q <= merge(fb2_q, wb_dat_i, wmask);
    end
  end

  // Writes of bank and modulator words
  for (genvar b = 0; b < PDSM_NBANK; b++) begin : g_bank
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        bank_q[b] <= PDSM_RST_WORD;
      end else if (wr && wb_adr_i == PDSM_OFF_BANK0 + 8'(4 * b)) begin
        bank_q[b] <= merge(bank_q[b], wb_dat_i, wmask);
      end
    end
    pdsm_post_div u_div (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .sel_i(bank_q[b][PDSM_BANK_SEL_LSB +: 2]),
      .count_i(bank_q[b][9:0]),
      .run_i(pwr_q),
      .clk_o(bclk_raw[b])
    );
  end

  for (genvar p = 0; p < 2; p++) begin : g_ss
    localparam logic [7:0] BASE = p == 0 ? PDSM_OFF_SS0 : PDSM_OFF_SS1;
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        ss_q[p] <= PDSM_RST_WORD;
        sdl_q[p] <= PDSM_RST_WORD;
        sdh_q[p] <= PDSM_RST_WORD;
      end else if (wr) begin
        if (wb_adr_i == BASE) ss_q[p] <= merge(ss_q[p], wb_dat_i, wmask);
        if (wb_adr_i == BASE + 8'h04) sdl_q[p] <= merge(sdl_q[p], wb_dat_i, wmask);
        if (wb_adr_i == BASE + 8'h08) sdh_q[p] <= merge(sdh_q[p], wb_dat_i, wmask);
      end
    end
    assign cfg[p] = '{step: ss_q[p][PDSM_CTL_STEP_LSB +: 4], cnt: ss_q[p][PDSM_CTL_CNT_LSB +: 4],
                      offset: ss_q[p][PDSM_CTL_OFF_LSB +: 6], lsb_randomize_enable: ss_q[p][PDSM_CTL_LSB_RANDOMIZE_ENABLE_BIT],
                      x2: ss_q[p][PDSM_CTL_X2_BIT], samp: {sdh_q[p][15:0], sdl_q[p]}};
    pdsm_ss_mod u_mod (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .cfg_i(cfg[p]),
      .frac_o(fr[p]),
      .active_o(act[p]),
      .period_o()
    );
  end

  // Outputs registered; third PLL power and minimum-frequency state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      vmin_q <= 1'b0;
      pwr_q <= 1'b0;
      bclk_q <= '0;
      f0_q <= 8'h00;
      f1_q <= 8'h00;
    end else begin
      vmin_q <= (fb2_q[11:0] == 12'h000);
      pwr_q <= (fb2_q[PDSM_FB_PRE_LSB +: 8] != 8'h00);
      bclk_q <= bclk_raw;
      f0_q <= fr[0];
      f1_q <= fr[1];
    end
  end

  assign wb_dat_o = rdat_q;
  assign wb_ack_o = ack_q;
  assign bank_clk_o = bclk_q;
  assign vco_min_o = vmin_q;
  assign pll2_pwr_o = pwr_q;
  assign frac0_o = f0_q;
  assign frac1_o = f1_q;

  a_ack_once: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");
  a_ack_follows: assert property (@(posedge clk_i) disable iff (rst_i)
    req |=> wb_ack_o) else $error("request not answered next cycle");
  a_pwr_track: assert property (@(posedge clk_i) disable iff (rst_i)
    fb2_q[23:16] != 8'h00 |=> pll2_pwr_o) else $error("powered PLL not flagged");
  a_vco_min: assert property (@(posedge clk_i) disable iff (rst_i)
    fb2_q[11:0] == 12'h000 |=> vco_min_o) else $error("zero feedback not flagged");
  a_pre_off: assert property (@(posedge clk_i) disable iff (rst_i)
    fb2_q[23:16] == 8'h00 [*4] |-> bank_clk_o == '0) else $error("banks run while powered down");

endmodule // pdsm_top
